//--- hdl/host_port_pkg.sv
/*
  Shared constants and types for the byte-wide host port of a four-channel serial device.
  Assumes a single 200 MHz clock and a host that drives the strobes, selects and index lines.
*/
package host_port_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CHANNELS  = 4;
  localparam int CHAN_W    = 2;
  localparam int INDEX_W   = 3;
  localparam int REGS      = 8;
  localparam int BYTE_W    = 8;

  // ----------------------------------------------------------------
  // Reset values and select-line roles
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;
  localparam int SEL_CS_BIT  = 0;
  localparam int SEL_LOW_BIT = 1;
  localparam int SEL_HI_BIT  = 2;

  typedef struct packed {
    logic                bus_style;
    logic                read_strobe_n;
    logic                write_strobe_n;
    logic [CHANNELS-1:0] channel_select_n;
    logic [INDEX_W-1:0]  reg_index;
    logic [BYTE_W-1:0]   host_byte;
  } host_pins_t;

  localparam host_pins_t PINS_IDLE = '{
    bus_style:        1'b1,
    read_strobe_n:    1'b1,
    write_strobe_n:   1'b1,
    channel_select_n: 4'hf,
    reg_index:        3'h0,
    host_byte:        8'h00
  };

  typedef enum {ST_IDLE, ST_READ, ST_WRITE} port_state_t;

  // Lowest-numbered asserted select wins when several are low.
  function automatic logic [CHAN_W-1:0] first_selected(input logic [CHANNELS-1:0] sel_n);
    logic [CHAN_W-1:0] ch;
    ch = '0;
    for (int i = CHANNELS - 1; i >= 0; i--)
    begin
      if (!sel_n[i])
      begin
        ch = CHAN_W'(i);
      end
    end
    return ch;
  endfunction

endpackage

//--- hdl/pin_sync.sv
/*
  Two-stage synchroniser for a vector of asynchronous pins.
  Assumes the bits are independent or held stable long enough to settle together.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule

`default_nettype wire

//--- hdl/host_read_port.sv
/*
  Byte-wide host port of a four-channel serial device with per-channel register storage.
  Assumes all host pins are asynchronous to CLK_I and that strobes last several clock periods.
*/
// How it works
// - The three index bits pick exactly one of the eight registers in the selected channel.
// - Eight data lines carry register bytes, driven only during reads and sampled otherwise.
// - With the bus-style pin high, the read strobe is an active-low read request.
// - A falling read strobe loads the indexed register byte and puts it on the data lines.
// - With the bus-style pin low, the read strobe is ignored and should be tied high.
// - In separate-strobe style a falling write strobe opens a write and its rise stores the byte.
// - In separate-strobe style a transfer runs only while any select is low, on the channel picked when it opens.
`timescale 1ns/1ps
`default_nettype none

module host_read_port
  import host_port_pkg::*;
(
  input  wire logic                       CLK_I,
  input  wire logic                       RST_I,
  input  wire host_port_pkg::host_pins_t  PINS_I,
  output logic [host_port_pkg::BYTE_W-1:0] HOST_BYTE_O,
  output logic                            HOST_BYTE_OE_N_O
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  host_pins_t pins_s;

  pin_sync #(
    .W    ($bits(host_pins_t)),
    .INIT (PINS_IDLE)
  ) u_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (PINS_I),
    .q_o   (pins_s)
  );

  // ----------------------------------------------------------------
  // Request decode for both bus styles
  // ----------------------------------------------------------------
  logic              any_sel;
  logic              cs_n;
  logic              rd_req;
  logic              wr_req;
  logic              write_done;
  logic [CHAN_W-1:0] chan_w;

  always_comb
  begin
    any_sel = ~&pins_s.channel_select_n;
    cs_n    = pins_s.channel_select_n[SEL_CS_BIT];
    if (pins_s.bus_style)
    begin
      chan_w     = first_selected(pins_s.channel_select_n);
      rd_req     = ~pins_s.read_strobe_n & any_sel;
      wr_req     = ~pins_s.write_strobe_n & any_sel;
      write_done = pins_s.write_strobe_n & any_sel;
    end
    else
    begin
      // Single read/write line: the read strobe pin plays no part.
      chan_w     = {pins_s.channel_select_n[SEL_HI_BIT], pins_s.channel_select_n[SEL_LOW_BIT]};
      rd_req     = ~cs_n & pins_s.write_strobe_n;
      wr_req     = ~cs_n & ~pins_s.write_strobe_n;
      write_done = cs_n;
    end
  end

  // ----------------------------------------------------------------
  // Transaction control and register storage
  // ----------------------------------------------------------------
  port_state_t        state_q;
  port_state_t        state_d;
  logic               rd_req_q;
  logic               wr_req_q;
  logic [CHAN_W-1:0]  chan_q;
  logic [CHAN_W-1:0]  chan_d;
  logic [INDEX_W-1:0] idx_q;
  logic [INDEX_W-1:0] idx_d;
  logic [BYTE_W-1:0]  data_q;
  logic [BYTE_W-1:0]  data_d;
  logic [BYTE_W-1:0]  regs_q [CHANNELS][REGS];
  logic [BYTE_W-1:0]  regs_d [CHANNELS][REGS];
  logic               read_start;
  logic               write_start;
  logic               store_en;
  logic [BYTE_W-1:0]  rd_pick;

  always_comb
  begin
    state_d     = state_q;
    chan_d      = chan_q;
    idx_d       = idx_q;
    data_d      = data_q;
    regs_d      = regs_q;
    rd_pick     = regs_q[chan_w][pins_s.reg_index];
    read_start  = 1'b0;
    write_start = 1'b0;
    store_en    = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (rd_req && !rd_req_q)
        begin
          read_start = 1'b1;
          state_d    = ST_READ;
          chan_d     = chan_w;
          idx_d      = pins_s.reg_index;
          data_d     = rd_pick;
        end
        else if (wr_req && !wr_req_q)
        begin
          write_start = 1'b1;
          state_d     = ST_WRITE;
          chan_d      = chan_w;
          idx_d       = pins_s.reg_index;
        end
      end
      ST_READ:
      begin
        // The host samples on its strobe rise; the drive ends with it.
        if (!rd_req)
        begin
          state_d = ST_IDLE;
        end
      end
      ST_WRITE:
      begin
        if (!wr_req)
        begin
          state_d  = ST_IDLE;
          store_en = write_done;
          if (write_done)
          begin
            regs_d[chan_q][idx_q] = pins_s.host_byte;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state_q  <= ST_IDLE;
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      chan_q   <= '0;
      idx_q    <= '0;
      data_q   <= REG_RESET;
      regs_q   <= '{default: '{default: REG_RESET}};
    end
    else
    begin
      state_q  <= state_d;
      rd_req_q <= rd_req;
      wr_req_q <= wr_req;
      chan_q   <= chan_d;
      idx_q    <= idx_d;
      data_q   <= data_d;
      regs_q   <= regs_d;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  assign HOST_BYTE_O      = data_q;
  assign HOST_BYTE_OE_N_O = ~((state_q == ST_READ) & rd_req);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_write_open;
    write_start ##1 (state_q == ST_WRITE);
  endsequence

  sequence s_read_open;
    read_start ##1 (state_q == ST_READ);
  endsequence

  a_index_single: assert property (@(posedge CLK_I) disable iff (RST_I)
    store_en |=> regs_q[$past(chan_q)][$past(idx_q) ^ 3'h1]
                 == $past(regs_q[chan_q][idx_q ^ 3'h1]))
    else $error("Write touched a register other than the indexed one.");

  a_drive_only_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    !HOST_BYTE_OE_N_O |-> (state_q == ST_READ) && $past(rd_req))
    else $error("Data lines driven outside a read.");

  a_style_read_req: assert property (@(posedge CLK_I) disable iff (RST_I)
    (pins_s.bus_style && !pins_s.read_strobe_n && any_sel && !rd_req_q
     && state_q == ST_IDLE) |=> (state_q == ST_READ) && !HOST_BYTE_OE_N_O)
    else $error("Read strobe in separate-strobe style did not start a read.");

  a_read_byte_out: assert property (@(posedge CLK_I) disable iff (RST_I)
    read_start |-> s_read_open ##0 (HOST_BYTE_O == $past(rd_pick)))
    else $error("Read did not present the indexed register byte.");

  a_read_ignored: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!pins_s.bus_style && pins_s.channel_select_n[SEL_CS_BIT]) |-> HOST_BYTE_OE_N_O)
    else $error("Read strobe acted in single-line style.");

  a_write_store: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_write_open ##[1:1000] store_en |=>
      regs_q[$past(chan_q)][$past(idx_q)] == $past(pins_s.host_byte))
    else $error("Write strobe rise did not store the data byte.");

  a_select_gates: assert property (@(posedge CLK_I) disable iff (RST_I)
    (pins_s.bus_style && !any_sel) |=> (state_q == ST_IDLE) && HOST_BYTE_OE_N_O)
    else $error("Channel took part without its select.");

  a_release_lines: assert property (@(posedge CLK_I) disable iff (RST_I)
    !rd_req |-> HOST_BYTE_OE_N_O)
    else $error("Data lines not released without a selected read.");

endmodule

`default_nettype wire

//--- dv/host_model.sv
/*
  Behavioural host processor that runs byte transfers on the device's parallel port.
  Assumes the bench calls its task from a falling clock edge and feeds back the device drive.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model
  import host_port_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic [host_port_pkg::BYTE_W-1:0] dev_byte_i,
  input  wire logic                        dev_oe_n_i,
  output var  host_port_pkg::host_pins_t   pins_o
);
  host_pins_t        p   = PINS_IDLE;
  logic [BYTE_W-1:0] drv = 8'h00;

  // The wire carries the device byte while it drives, otherwise the host's value.
  always_comb
  begin
    pins_o = p;
    pins_o.host_byte = dev_oe_n_i ? drv : dev_byte_i;
  end

  // ----------------------------------------------------------------
  // One transfer; ab drops the selects before the strobe rises.
  // ----------------------------------------------------------------
  task automatic xfer(input logic st, input logic wr, input logic ab, input logic [1:0] ch,
                      input logic [2:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    p.bus_style = st;
    p.reg_index = idx;
    p.write_strobe_n = st | ~wr;
    drv = wr ? d : ~pins_o.host_byte;
    p.channel_select_n = st ? ~(4'h1 << ch) : {1'b1, ch, 1'b1};
    repeat (2) @(negedge clk_i);
    if (st && wr) p.write_strobe_n = 1'b0;
    else if (st) p.read_strobe_n = 1'b0;
    else p.channel_select_n[0] = 1'b0;
    repeat (8) @(negedge clk_i);
    q = pins_o.host_byte;
    if (ab) p.channel_select_n = 4'hf;
    else if (st) {p.read_strobe_n, p.write_strobe_n} = 2'b11;
    else p.channel_select_n[0] = 1'b1;
    repeat (4) @(negedge clk_i);
    p = PINS_IDLE;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

`default_nettype wire

//--- dv/tb.sv
/*
  Self-checking bench for the host port: table of writes and cross-style reads, then edge cases.
  Assumes the host model drives all pins and resolves the data wire.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import host_port_pkg::*;

  typedef struct packed {
    logic       st;
    logic [1:0] ch;
    logic [2:0] idx;
    logic [7:0] d;
  } row_t;

  row_t rows [10] = '{
    {1'b1, 2'h0, 3'h0, 8'ha5}, {1'b1, 2'h1, 3'h7, 8'h3c}, {1'b1, 2'h2, 3'h3, 8'h81},
    {1'b1, 2'h3, 3'h5, 8'h7e}, {1'b0, 2'h0, 3'h1, 8'h5a}, {1'b0, 2'h1, 3'h2, 8'hc3},
    {1'b0, 2'h2, 3'h4, 8'hff}, {1'b0, 2'h3, 3'h6, 8'h01}, {1'b1, 2'h0, 3'h7, 8'h96},
    {1'b0, 2'h3, 3'h0, 8'he7}};

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  host_pins_t        pins;
  logic [BYTE_W-1:0] byte_o;
  logic              oe_n;
  logic [7:0]        q;
  int                num_errors = 0;
  int                n_checks = 0;

  initial forever #2.5 clk = ~clk;

  host_model i_host_model (.clk_i(clk), .dev_byte_i(byte_o), .dev_oe_n_i(oe_n), .pins_o(pins));

  host_read_port i_host_read_port (.CLK_I(clk), .RST_I(rst), .PINS_I(pins),
                                   .HOST_BYTE_O(byte_o), .HOST_BYTE_OE_N_O(oe_n));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_oe(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: drive enable %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge clk);
    chk(byte_o, 8'h00);
    chk_oe(oe_n, 1'b1);
    rst = 1'b0;
    foreach (rows[i])
    begin
      i_host_model.xfer(rows[i].st, 1, 0, rows[i].ch, rows[i].idx, rows[i].d, q);
    end
    foreach (rows[i])
    begin
      i_host_model.xfer(~rows[i].st, 0, 0, rows[i].ch, rows[i].idx, 8'h00, q);
      chk(q, rows[i].d);
    end
    // Write dropped by releasing the select early leaves the old byte.
    i_host_model.xfer(1, 1, 1, 2'h0, 3'h0, 8'h11, q);
    i_host_model.xfer(1, 0, 0, 2'h0, 3'h0, 8'h00, q);
    chk(q, 8'ha5);
    // Read strobe with no select must not drive.
    i_host_model.p.read_strobe_n = 1'b0;
    repeat (8) @(negedge clk);
    chk_oe(oe_n, 1'b1);
    // In single-line style a low read strobe with the chip select high must not drive.
    i_host_model.p.bus_style = 1'b0;
    i_host_model.p.channel_select_n = 4'h9;
    repeat (8) @(negedge clk);
    chk_oe(oe_n, 1'b1);
    // Single-line style write with the read strobe low must not drive.
    i_host_model.p.write_strobe_n = 1'b0;
    i_host_model.p.channel_select_n = 4'he;
    repeat (8) @(negedge clk);
    chk_oe(oe_n, 1'b1);
    i_host_model.p = PINS_IDLE;
    repeat (6) @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk_oe(oe_n, 1'b1);
    chk(byte_o, 8'h00);
    rst = 1'b0;
    i_host_model.xfer(1, 0, 0, 2'h1, 3'h7, 8'h00, q);
    chk(q, 8'h00);
    end_sim();
  end
endmodule

`default_nettype wire
